// ### core/twc_pkg.sv
/*
  Package for the three-wire configuration port: frame layout, register
  addresses, reset values, field positions and state encodings.
  Assumes both ends of the link and the bench compile it first.
*/
package twc_pkg;

  // Frame layout
  localparam int unsigned ADDR_W  = 4;
  localparam int unsigned DATA_W  = 12;
  localparam int unsigned FRAME_W = 16;
  localparam logic [4:0]  FRAME_LAST = 5'h0F;  // Index of the 16th bit
  localparam logic [4:0]  FRAME_DONE = 5'h10;  // Counter value after transfer

  // Register addresses
  localparam logic [3:0] ADDR_STATE  = 4'h0;
  localparam logic [3:0] ADDR_GAIN   = 4'h1;
  localparam logic [3:0] ADDR_OFFSET = 4'h2;
  localparam logic [3:0] ADDR_DELAY  = 4'h3;
  localparam logic [3:0] ADDR_TEST   = 4'h5;

  // Reset values
  localparam logic [11:0] RST_STATE  = 12'h7FF;
  localparam logic [11:0] RST_GAIN   = 12'h200;
  localparam logic [11:0] RST_OFFSET = 12'h200;
  localparam logic [11:0] RST_DELAY  = 12'h002;
  localparam logic [11:0] RST_TEST   = 12'h007;

  // State register field positions
  localparam int unsigned BIT_DEMUX  = 0;
  localparam int unsigned BIT_DTRIM  = 1;
  localparam int unsigned BIT_PATN   = 2;
  localparam int unsigned BIT_THIN   = 3;
  localparam int unsigned BIT_EDGE   = 7;
  localparam int unsigned BIT_MARK   = 8;

  // Other fields
  localparam int unsigned TRIM_W      = 10;  // Gain and offset code width
  localparam int unsigned FINE_W      = 10;  // Fine delay field
  localparam int unsigned COARSE_W    = 2;   // Coarse delay field, bits 11:10
  localparam int unsigned COARSE_LSB  = 10;
  localparam int unsigned TEST_TYPE_W = 2;
  localparam int unsigned BIT_HOLD    = 2;   // Hold stage test enable in test reg

  // Test type encodings
  localparam logic [1:0] TT_ALL_LOW  = 2'h0;
  localparam logic [1:0] TT_ALL_HIGH = 2'h1;
  localparam logic [1:0] TT_UNUSED   = 2'h2;
  localparam logic [1:0] TT_ALIGN    = 2'h3;

  // Decimation, pattern and marker figures
  localparam logic [2:0] THIN_LAST    = 3'h7;  // One of every 8
  localparam logic [3:0] ALIGN_PERIOD = 4'hF;  // Pattern period 16
  localparam logic [3:0] MARK_LATENCY = 4'h4;  // Marker pipeline latency

  // Host clock divider: half period in core cycles
  localparam logic [3:0] SCK_HALF = 4'h4;

  typedef enum logic [1:0] {
    TWC_IDLE  = 2'b00,
    TWC_SHIFT = 2'b01,
    TWC_HOLD  = 2'b10
  } twc_rx_state_t;

  typedef enum logic [1:0] {
    TWC_H_IDLE = 2'b00,
    TWC_H_SEND = 2'b01,
    TWC_H_GAP  = 2'b10
  } twc_tx_state_t;

endpackage : twc_pkg

// ### core/twc_link_if.sv
/*
  Link between the host controller and the configuration port: serial
  clock, load strobe, data, and the port's reset and enable pins.
  Assumes the host drives every wire; the device only listens.
*/
`timescale 1ns/1ps
`default_nettype none

interface twc_link_if;
  logic sck;         // Serial clock
  logic load_low;    // Frame strobe, active low
  logic mosi;        // Serial data, MSB first
  logic rst_port_n;  // Port reset, active low
  logic enable_low;  // Serial interface enable, active low

  modport host (
    output sck,
    output load_low,
    output mosi,
    output rst_port_n,
    output enable_low
  );

  modport device (
    input sck,
    input load_low,
    input mosi,
    input rst_port_n,
    input enable_low
  );
endinterface : twc_link_if

`default_nettype wire

// ### core/twc_config_port.sv
/*
  Device end: three-wire configuration port, register bank and the small
  digital functions steered by it (demux, decimation, test pattern,
  sync edge and trigger marker).
  Assumes the link pins are asynchronous to clock; they are resynchronised.
*/
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Up to 16 write-only 12-bit registers
// - Frame: 4 address then 12 data, MSB first
// - Strobe and data sampled each serial rising edge
// - Host keeps strobe high when idle
// - Frame starts on first low strobe, held low
// - One high strobe cycle separates frames
// - Early strobe high abandons frame, no change
// - Full frame loads register; extra cycles ignored
// - Always 12 data bits; unused upper discarded
// - Port reset low with strobe low loads defaults
// - Port works only while enable is low; port reset still loads defaults with enable high
// - Defaults 7FF, 200, 200, 002, 7
// - Disabled port: 1:1 demux, half speed
// - D1 low enables delay trim; D0 demux ratio
// - D2 low selects test pattern mode
// - D3 low keeps one sample in eight, one in 16 in 1:2 demux
// - D7 selects sync edge: 0 rise, 1 fall
// - D8 low trigger mode, high sync mode
// - Trigger mode copies sync pulse to markers
// - Pattern generator free running, sync undisturbed
// - Gain code is bits 9 to 0
// - Delay: coarse top 2 bits, fine 10
// - Test type: low, high, unused, alignment
module twc_config_port (
  // Clock and reset
  input  wire logic          clock,
  input  wire logic          rst_n,
  // Serial link
  twc_link_if.device         link,
  // Converter-side controls
  input  wire logic          sync_in,
  output logic               demux_ratio_select,
  output logic               half_speed,
  output logic               delay_trim_enable_low,
  output logic               pattern_mode_enable_low,
  output logic               thin_output_enable_low,
  output logic               clear_edge_polarity,
  output logic               pulse_marker_select,
  output logic               hold_stage_test_enable,
  output logic [9:0]         amplitude_trim,
  output logic [9:0]         level_shift_trim,
  output logic [1:0]         delay_coarse,
  output logic [9:0]         delay_fine,
  output logic [1:0]         test_type,
  // Sample-rate views of the steered functions
  output logic               sample_keep,
  output logic               pattern_bit,
  output logic               sync_event,
  output logic               marker_out_port_a,
  output logic               marker_out_port_b
);

  // Three-stage synchronisers: sck, strobe, data, port reset, enable, sync
  localparam int unsigned NSYN = 6;
  // Idle level of each pin; a sync stage starting high would fake an edge after reset
  localparam logic [NSYN-1:0] SYN_RST = 6'h1F;
  logic [NSYN-1:0] raw;
  logic [NSYN-1:0] s1_q, s2_q, s3_q;
  logic [NSYN-1:0] stable_q;
  assign raw = {sync_in, link.enable_low, link.rst_port_n, link.mosi,
                link.load_low, link.sck};

  // Second and third stage must agree before a change counts
  genvar g;
  generate
    for (g = 0; g < NSYN; g++) begin : g_sync
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          s1_q[g]     <= SYN_RST[g];
          s2_q[g]     <= SYN_RST[g];
          s3_q[g]     <= SYN_RST[g];
          stable_q[g] <= SYN_RST[g];
        end else begin
          s1_q[g] <= raw[g];
          s2_q[g] <= s1_q[g];
          s3_q[g] <= s2_q[g];
          if (s2_q[g] == s3_q[g]) begin
            stable_q[g] <= s3_q[g];
          end
        end
      end
    end
  endgenerate

  logic sck_s, load_s, mosi_s, prst_s, en_s, sync_s;
  assign {sync_s, en_s, prst_s, mosi_s, load_s, sck_s} = stable_q;

  // Serial clock edge detect; sld and data sampled on rising edge
  logic sck_prev_q;
  logic sck_rise;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= sck_s;
    end
  end
  assign sck_rise = sck_s & ~sck_prev_q;

  // Port active only when enabled; port reset is a synchronised level
  logic port_on;
  logic defaults_load;
  assign port_on       = ~en_s;
  assign defaults_load = ~prst_s & ~load_s;

  // Frame receiver: counts low-strobe cycles, shifts MSB first
  twc_pkg::twc_rx_state_t st_q;
  logic [4:0]  cnt_q;
  logic [15:0] shift_q;
  logic        commit;
  assign commit = port_on && sck_rise && !load_s && st_q == twc_pkg::TWC_SHIFT
                  && cnt_q == twc_pkg::FRAME_LAST;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= twc_pkg::TWC_IDLE;
      cnt_q   <= 5'h00;
      shift_q <= 16'h0000;
    end else if (!port_on || !prst_s) begin
      st_q  <= twc_pkg::TWC_IDLE;
      cnt_q <= 5'h00;
    end else if (sck_rise) begin
      case (st_q)
        twc_pkg::TWC_IDLE: begin
          if (!load_s) begin
            st_q    <= twc_pkg::TWC_SHIFT;
            cnt_q   <= 5'h01;
            shift_q <= {shift_q[14:0], mosi_s};
          end
        end
        twc_pkg::TWC_SHIFT: begin
          if (load_s) begin
            st_q  <= twc_pkg::TWC_IDLE;
            cnt_q <= 5'h00;
          end else begin
            shift_q <= {shift_q[14:0], mosi_s};
            cnt_q   <= cnt_q + 5'h01;
            if (cnt_q == twc_pkg::FRAME_LAST) begin
              st_q <= twc_pkg::TWC_HOLD;
            end
          end
        end
        twc_pkg::TWC_HOLD: begin
          // Extra low cycles ignored; one high cycle re-arms
          if (load_s) begin
            st_q  <= twc_pkg::TWC_IDLE;
            cnt_q <= 5'h00;
          end
        end
        default: begin
          st_q <= twc_pkg::TWC_IDLE;
        end
      endcase
    end
  end

  // Completed frame: address in top four bits, data in low twelve
  logic [3:0]  wr_addr;
  logic [11:0] wr_data;
  assign wr_addr = shift_q[14:11];
  assign wr_data = {shift_q[10:0], mosi_s};

  // Register bank; reserved addresses fall through untouched
  logic [11:0] state_control_q, gain_trim_code_q, offset_trim_code_q;
  logic [11:0] sample_delay_trim_code_q, test_pattern_control_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_control_q          <= twc_pkg::RST_STATE;
      gain_trim_code_q         <= twc_pkg::RST_GAIN;
      offset_trim_code_q       <= twc_pkg::RST_OFFSET;
      sample_delay_trim_code_q <= twc_pkg::RST_DELAY;
      test_pattern_control_q   <= twc_pkg::RST_TEST;
    end else if (defaults_load) begin
      state_control_q          <= twc_pkg::RST_STATE;
      gain_trim_code_q         <= twc_pkg::RST_GAIN;
      offset_trim_code_q       <= twc_pkg::RST_OFFSET;
      sample_delay_trim_code_q <= twc_pkg::RST_DELAY;
      test_pattern_control_q   <= twc_pkg::RST_TEST;
    end else if (commit) begin
      if (wr_addr == twc_pkg::ADDR_STATE) begin
        state_control_q <= wr_data;
      end else if (wr_addr == twc_pkg::ADDR_GAIN) begin
        gain_trim_code_q <= wr_data;
      end else if (wr_addr == twc_pkg::ADDR_OFFSET) begin
        offset_trim_code_q <= wr_data;
      end else if (wr_addr == twc_pkg::ADDR_DELAY) begin
        sample_delay_trim_code_q <= wr_data;
      end else if (wr_addr == twc_pkg::ADDR_TEST) begin
        test_pattern_control_q <= wr_data;
      end  // Other addresses change nothing
    end
  end

  // Decoded controls; disabled port forces 1:1 at half speed
  always_comb begin
    demux_ratio_select      = port_on & state_control_q[twc_pkg::BIT_DEMUX];
    half_speed              = ~port_on;
    delay_trim_enable_low   = state_control_q[twc_pkg::BIT_DTRIM];
    pattern_mode_enable_low = state_control_q[twc_pkg::BIT_PATN];
    thin_output_enable_low  = state_control_q[twc_pkg::BIT_THIN];
    clear_edge_polarity     = state_control_q[twc_pkg::BIT_EDGE];
    pulse_marker_select     = state_control_q[twc_pkg::BIT_MARK];
    // Upper bits of narrow fields discarded
    amplitude_trim   = gain_trim_code_q[twc_pkg::TRIM_W-1:0];
    level_shift_trim = offset_trim_code_q[twc_pkg::TRIM_W-1:0];
    delay_coarse     = sample_delay_trim_code_q[11:twc_pkg::COARSE_LSB];
    delay_fine       = sample_delay_trim_code_q[twc_pkg::FINE_W-1:0];
    test_type        = test_pattern_control_q[twc_pkg::TEST_TYPE_W-1:0];
    hold_stage_test_enable = test_pattern_control_q[twc_pkg::BIT_HOLD];
  end

  // Free-running decimation and pattern phase; mode changes never reset it
  logic [3:0] phase_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 4'h0;
    end else begin
      phase_q <= phase_q + 4'h1;
    end
  end

  // One in 8 kept; in 1:2 demux one in 16
  always_comb begin
    if (thin_output_enable_low) begin
      sample_keep = 1'b1;
    end else if (demux_ratio_select) begin
      sample_keep = (phase_q == twc_pkg::ALIGN_PERIOD);
    end else begin
      sample_keep = (phase_q[2:0] == twc_pkg::THIN_LAST);
    end
  end

  // Test output bit: constant levels or a period-16 alignment pattern
  logic align_bit;
  assign align_bit = (phase_q >= 4'h4) & (phase_q[0] | phase_q[3]);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pattern_bit <= 1'b0;
    end else if (pattern_mode_enable_low) begin
      pattern_bit <= 1'b0;
    end else begin
      case (test_type)
        twc_pkg::TT_ALL_LOW:  pattern_bit <= 1'b0;
        twc_pkg::TT_ALL_HIGH: pattern_bit <= 1'b1;
        twc_pkg::TT_ALIGN:    pattern_bit <= align_bit;
        default:              pattern_bit <= 1'b0;
      endcase
    end
  end

  // Sync edge detect on the selected polarity
  logic sync_prev_q;
  logic sync_edge;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_prev_q <= 1'b0;
    end else begin
      sync_prev_q <= sync_s;
    end
  end
  assign sync_edge = clear_edge_polarity ? (sync_prev_q & ~sync_s)
                                         : (~sync_prev_q & sync_s);

  // Sync mode resynchronises; trigger mode inhibits and marks instead
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_event <= 1'b0;
    end else begin
      sync_event <= sync_edge & pulse_marker_select;
    end
  end

  // Marker pipeline: trigger pulse appears on both ports after latency
  logic [twc_pkg::MARK_LATENCY-1:0] mark_pipe_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mark_pipe_q       <= '0;
      marker_out_port_a <= 1'b0;
      marker_out_port_b <= 1'b0;
    end else begin
      mark_pipe_q <= {mark_pipe_q[twc_pkg::MARK_LATENCY-2:0],
                      sync_s & ~pulse_marker_select};
      marker_out_port_a <= mark_pipe_q[twc_pkg::MARK_LATENCY-1];
      marker_out_port_b <= mark_pipe_q[twc_pkg::MARK_LATENCY-1];
    end
  end

endmodule : twc_config_port

`default_nettype wire

// ### core/twc_host.sv
/*
  Host end: takes one address and data word per request and shifts a
  16-bit frame out on a divided serial clock with the strobe held low.
  Assumes requests come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module twc_host (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Request side
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire logic [3:0]  req_addr,
  input  wire logic [11:0] req_data,
  input  wire logic        port_enable,
  input  wire logic        port_reset,
  output logic             done,
  // Serial link
  twc_link_if.host         link
);

  twc_pkg::twc_tx_state_t st_q;
  logic [3:0]  div_q;
  logic        sck_q;
  logic [15:0] sh_q;
  logic [4:0]  bits_q;
  logic        load_low_q;
  logic        link_bit_q;

  // Frames go out even with the port disabled; the device decides to ignore them
  assign req_ready = (st_q == twc_pkg::TWC_H_IDLE) && !port_reset;

  // Serial clock divider, runs always; data changes on the falling edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 4'h0;
      sck_q <= 1'b0;
    end else if (div_q == twc_pkg::SCK_HALF - 4'h1) begin
      div_q <= 4'h0;
      sck_q <= ~sck_q;
    end else begin
      div_q <= div_q + 4'h1;
    end
  end

  logic fall;
  assign fall = sck_q && div_q == twc_pkg::SCK_HALF - 4'h1;

  // Strobe stays high when idle, at least two high cycles between frames
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q       <= twc_pkg::TWC_H_IDLE;
      sh_q       <= 16'h0000;
      bits_q     <= 5'h00;
      load_low_q <= 1'b1;
      link_bit_q <= 1'b0;
      done       <= 1'b0;
    end else begin
      done <= 1'b0;
      case (st_q)
        twc_pkg::TWC_H_IDLE: begin
          if (req_valid && req_ready) begin
            sh_q <= {req_addr, req_data};
            st_q <= twc_pkg::TWC_H_SEND;
            bits_q <= 5'h00;
          end
        end
        twc_pkg::TWC_H_SEND: begin
          if (fall) begin
            if (bits_q == twc_pkg::FRAME_DONE) begin
              load_low_q <= 1'b1;
              st_q       <= twc_pkg::TWC_H_GAP;
            end else begin
              load_low_q <= 1'b0;
              link_bit_q <= sh_q[15];
              sh_q       <= {sh_q[14:0], 1'b0};
              bits_q     <= bits_q + 5'h01;
            end
          end
        end
        twc_pkg::TWC_H_GAP: begin
          if (fall) begin
            st_q <= twc_pkg::TWC_H_IDLE;
            done <= 1'b1;
          end
        end
        default: begin
          st_q <= twc_pkg::TWC_H_IDLE;
        end
      endcase
    end
  end

  assign link.sck        = sck_q;
  // Port reset only acts with the strobe low, so pull it low as well
  assign link.load_low   = load_low_q & ~port_reset;
  assign link.mosi       = link_bit_q;
  assign link.rst_port_n = ~port_reset;
  assign link.enable_low = ~port_enable;

endmodule : twc_host

`default_nettype wire

// ### verification/twc_link_monitor.sv
/*
  Checker for the serial link: strobe framing and serial clock shape.
  Assumes it is placed beside the link interface and runs on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none

module twc_link_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Link wires
  input wire logic sck,
  input wire logic load_low,
  input wire logic mosi,
  input wire logic rst_port_n,
  input wire logic enable_low
);
  logic       sck_q;
  logic [4:0] bits_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Serial clock history, for finding its edges
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) sck_q <= 1'b0;
    else sck_q <= sck;
  end

  // Bits sampled in this low strobe; a port reset voids the count
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) bits_q <= 5'h00;
    else if (load_low || !rst_port_n) bits_q <= 5'h00;
    else if (sck && !sck_q) bits_q <= bits_q + 5'h01;
  end

  a_frame_sixteen_bits: assert property (
    $rose(load_low) && bits_q != 5'h00 |-> bits_q == 5'h10)
    else $error("frame did not carry sixteen bits");
  a_gap_one_sample: assert property (
    $rose(load_low) && bits_q != 5'h00 |-> load_low throughout (##[1:12] $rose(sck)))
    else $error("strobe not high over a sample between frames");
  a_strobe_held_low: assert property (
    bits_q != 5'h00 && bits_q != 5'h10 && rst_port_n |-> !load_low)
    else $error("strobe released inside a frame");
  a_start_sck_low: assert property (
    $fell(load_low) && rst_port_n |-> !sck)
    else $error("frame started with serial clock high");
  a_setup_stable: assert property (
    $rose(sck) && rst_port_n && $past(rst_port_n) |-> $stable(load_low) && $stable(mosi))
    else $error("strobe or data moved at the sampling edge");
  a_hold_stable: assert property (
    $rose(sck) && rst_port_n |=> !rst_port_n || ($stable(load_low) && $stable(mosi)))
    else $error("strobe or data moved right after sampling");
  a_end_strobe_high: assert property (
    bits_q == 5'h10 && $fell(sck) |-> load_low)
    else $error("strobe still low after a full frame");
  a_enable_steady: assert property (
    bits_q != 5'h00 && bits_q != 5'h10 |-> $stable(enable_low))
    else $error("port enable moved inside a frame");
  a_sck_high_time: assert property (
    $rose(sck) |-> sck[*4] ##1 !sck)
    else $error("serial clock high time wrong");
  a_sck_low_time: assert property (
    $fell(sck) |-> (!sck)[*4])
    else $error("serial clock low time too short");
endmodule // twc_link_monitor

`default_nettype wire

// ### verification/test_three_wire_config_write_port.sv
/*
  Bench: host end and device end joined by the link; writes go in through
  the host request side and are judged at the device's decoded outputs.
  Assumes the core package and both design ends are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module test_three_wire_config_write_port;
  logic        clock, rst_n, req_valid, req_ready, port_enable, port_reset, done, sync_in;
  logic [3:0]  req_addr;
  logic [11:0] req_data, seen_state, seen_test;
  logic        demux_ratio_select, half_speed, delay_trim_enable_low, pattern_mode_enable_low;
  logic        thin_output_enable_low, clear_edge_polarity, pulse_marker_select;
  logic        hold_stage_test_enable, sync_event, marker_out_port_a, marker_out_port_b;
  logic        sample_keep, pattern_bit;
  logic [9:0]  amplitude_trim, level_shift_trim, delay_fine;
  logic [1:0]  delay_coarse, test_type;
  logic [11:0] model [16];
  logic [11:0] pat [5] = '{12'hC00, 12'hFFF, 12'h3A1, 12'h6F2, 12'h85B};
  localparam logic [11:0] ALIGN_ONES = 12'h00A;  // Ones per period of the chosen alignment pattern
  logic [3:0]  adr [5] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h5};
  int          err_total = 0;
  int          checks_done = 0;
  int          cycles = 0;

  twc_link_if twc_link_if_i ();

  twc_host twc_host_i (.clock, .rst_n, .req_valid, .req_ready, .req_addr, .req_data,
    .port_enable, .port_reset, .done, .link(twc_link_if_i.host));

  twc_config_port twc_config_port_i (.clock, .rst_n, .link(twc_link_if_i.device), .sync_in,
    .demux_ratio_select, .half_speed, .delay_trim_enable_low, .pattern_mode_enable_low,
    .thin_output_enable_low, .clear_edge_polarity, .pulse_marker_select,
    .hold_stage_test_enable, .amplitude_trim, .level_shift_trim, .delay_coarse, .delay_fine,
    .test_type, .sample_keep, .pattern_bit, .sync_event, .marker_out_port_a,
    .marker_out_port_b);

  twc_link_monitor twc_link_monitor_i (.clock, .rst_n, .sck(twc_link_if_i.sck),
    .load_low(twc_link_if_i.load_low), .mosi(twc_link_if_i.mosi),
    .rst_port_n(twc_link_if_i.rst_port_n), .enable_low(twc_link_if_i.enable_low));

  // Observable state bits; D4 to D6 and D9 to D11 drive nothing
  assign seen_state = {3'h0, pulse_marker_select, clear_edge_polarity, 3'h0,
    thin_output_enable_low, pattern_mode_enable_low, delay_trim_enable_low, demux_ratio_select};
  assign seen_test = {9'h000, hold_stage_test_enable, test_type};

  // Core clock, 40 ns
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Hang guard; a full run needs just under a third of this
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_total = err_total + 1;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic set_defaults();
    model[0] = 12'h7FF;
    model[1] = 12'h200;
    model[2] = 12'h200;
    model[3] = 12'h002;
    model[5] = 12'h007;
  endtask

  // One frame through the host; returns once the host reports it sent
  task automatic write_reg(input logic [3:0] a, input logic [11:0] d);
    int k;
    @(posedge clock);
    req_valid <= 1'b1;
    req_addr  <= a;
    req_data  <= d;
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (req_ready !== 1'b1 && k < 400);
    @(posedge clock);
    req_valid <= 1'b0;
    do begin
      @(negedge clock);
      k++;
    end while (done !== 1'b1 && k < 800);
    if (k >= 800) chk("done", 12'h001, 12'h000);
    if (port_enable && (a < 4'h4 || a == 4'h5)) model[a] = d;
  endtask

  // Margin for the device's resynchroniser, then every register view
  task automatic check_all();
    logic [11:0] keep_n;
    logic [11:0] ones_n;
    logic [11:0] ones_exp;
    repeat (8) @(negedge clock);
    chk("state", model[0] & 12'h18F, seen_state);
    chk("gain", model[1] & 12'h3FF, {2'h0, amplitude_trim});
    chk("offset", model[2] & 12'h3FF, {2'h0, level_shift_trim});
    chk("delay", model[3], {delay_coarse, delay_fine});
    chk("test", model[5] & 12'h007, seen_test);
    // One full phase period: count kept samples and pattern ones
    keep_n = 12'h000;
    ones_n = 12'h000;
    repeat (16) begin
      @(negedge clock);
      keep_n = keep_n + {11'h000, sample_keep};
      ones_n = ones_n + {11'h000, pattern_bit};
    end
    ones_exp = 12'h000;
    if (!model[0][2] && model[5][1:0] == 2'h1) ones_exp = 12'h010;
    if (!model[0][2] && model[5][1:0] == 2'h3) ones_exp = ALIGN_ONES;
    chk("kept", model[0][3] ? 12'h010 : (model[0][0] ? 12'h001 : 12'h002), keep_n);
    chk("pattern ones", ones_exp, ones_n);
  endtask

  // Move the sync input; wait a bounded time for an event, then look at markers
  task automatic sync_probe(input logic lvl, input logic mark, input logic evt);
    int k;
    @(posedge clock);
    sync_in <= lvl;
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (sync_event !== 1'b1 && k < 10);
    chk("sync event", {11'h000, evt}, {11'h000, sync_event});
    chk("markers", {10'h000, mark, mark}, {10'h000, marker_out_port_a, marker_out_port_b});
  endtask

  initial begin
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_addr = 4'h0;
    req_data = 12'h000;
    port_enable = 1'b1;
    port_reset = 1'b0;
    sync_in = 1'b0;
    foreach (model[i]) model[i] = 12'h000;
    set_defaults();
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    check_all();
    $display("test reset values finished");
    // Frames back to back, codes of every field and test type, upper bits set
    for (int p = 0; p < 5; p++) begin
      for (int r = 0; r < 5; r++) write_reg(adr[r], pat[p]);
      check_all();
    end
    $display("test register writes finished");
    for (int a = 4; a < 16; a++) if (a != 5) write_reg(4'(a), 12'hABC);
    check_all();
    $display("test reserved addresses finished");
    // Disabled port: fixed 1:1 at half speed, frames ignored
    @(posedge clock);
    port_enable <= 1'b0;
    repeat (10) @(negedge clock);
    chk("half speed", 12'h001, {11'h000, half_speed});
    chk("demux", 12'h000, {11'h000, demux_ratio_select});
    write_reg(4'h1, 12'h155);
    @(posedge clock);
    port_enable <= 1'b1;
    check_all();
    $display("test disabled port finished");
    write_reg(4'h0, 12'h07F);
    sync_probe(1'b1, 1'b1, 1'b0);
    sync_probe(1'b0, 1'b0, 1'b0);
    write_reg(4'h0, 12'h17F);
    sync_probe(1'b1, 1'b0, 1'b1);
    sync_probe(1'b0, 1'b0, 1'b0);
    write_reg(4'h0, 12'h1FF);
    sync_probe(1'b1, 1'b0, 1'b0);
    sync_probe(1'b0, 1'b0, 1'b1);
    $display("test sync and trigger finished");
    // Port reset brings back the default settings
    @(posedge clock);
    port_reset <= 1'b1;
    repeat (20) @(posedge clock);
    port_reset <= 1'b0;
    set_defaults();
    check_all();
    $display("test port reset finished");
    close_out();
  end
endmodule // test_three_wire_config_write_port

`default_nettype wire
